// >>> common/rifd_params.svh
// Constants for the instruction field decoder
// What this block does
// - Split 14-bit word into opcode and operands
// - Classify as byte, bit or literal/control
// - Destination bit: 0 accumulator, 1 file
// - File address field spans 0x00 to 0x7F
// - Bit index picks one of eight bits
// - Literal is eight or eleven bits wide
// - Don't-care encoding bits are ignored
// - Skip or branch takes two cycles, NOP second
// - Instruction cycle is four clock periods
// - Byte ops: top 00, opcode, d, file
// - Bit ops: top 01, opcode, bit, file
// - Literal ops: top 11, opcode, 8-bit literal
`ifndef RIFD_PARAMS_SVH
`define RIFD_PARAMS_SVH
// ----------------------------------------
// Encoding fields
// ----------------------------------------
`define RIFD_INSN_W      14
`define RIFD_TOP_HI      13
`define RIFD_TOP_LO      12
`define RIFD_TOP_BYTE    2'h0
`define RIFD_TOP_BIT     2'h1
`define RIFD_TOP_JUMP    2'h2
`define RIFD_TOP_LIT     2'h3
`define RIFD_DEST_BIT    7
`define RIFD_FILE_W      7
`define RIFD_BIT_LO      7
`define RIFD_BIT_W       3
`define RIFD_LIT8_W      8
`define RIFD_LIT11_W     11
`define RIFD_BOP_SKIPC   2'h2
`define RIFD_BOP_SKIPS   2'h3
`define RIFD_OP_RRF      4'hC
`define RIFD_OP_DECSZ    4'hB
`define RIFD_OP_INCSZ    4'hF
`define RIFD_OP_IORL     4'h8
`define RIFD_OP_RETLW_HI 2'h1
`define RIFD_RETURN      14'h0008
`define RIFD_RETFIE      14'h0009
`define RIFD_NOP_WORD    14'h0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define RIFD_PHASES      4
`define RIFD_PH_W        2
`endif

// >>> common/rifd_pkg.sv
// Types for the instruction field decoder
package rifd_pkg;
	typedef enum logic [2:0] {
		RIFD_CLS_BYTE = 3'h1,
		RIFD_CLS_BIT  = 3'h2,
		RIFD_CLS_LIT  = 3'h4
	} rifd_class_t;
endpackage

// >>> hw/rifd_decoder.sv
// Instruction field decoder for the 14-bit core
`timescale 1ns/10ps
`include "rifd_params.svh"
module rifd_decoder #(
	parameter int INSN_W = `RIFD_INSN_W
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	input  wire logic [INSN_W-1:0]           fetch_word,
	input  wire logic                        cond_true,
	output rifd_pkg::rifd_class_t            insn_class,
	output logic      [3:0]                  op_code,
	output logic                             dest_file,
	output logic      [`RIFD_FILE_W-1:0]     file_addr,
	output logic      [`RIFD_BIT_W-1:0]      bit_index,
	output logic      [`RIFD_LIT8_W-1:0]     lit8,
	output logic      [`RIFD_LIT11_W-1:0]    lit11,
	output logic                             is_jump,
	output logic                             is_nop_cycle,
	output logic                             cyc_strobe,
	output logic      [`RIFD_PH_W-1:0]       cyc_phase
);
	initial begin
		if (INSN_W != 14) $error("rifd_decoder: instruction width must be 14");
	end
	// ----------------------------------------
	// Phase sequencing
	// ----------------------------------------
	logic [`RIFD_PH_W-1:0] phase;
	logic                  cyc_start;
	rifd_phase_gen #(.PHASES(`RIFD_PHASES)) u_phase (
		.core_clk (core_clk),
		.rst      (rst),
		.phase    (phase),
		.cyc_start(cyc_start)
	);
	// ----------------------------------------
	// Combinational field split
	// ----------------------------------------
	logic [1:0]  top;
	logic [13:0] w;
	rifd_pkg::rifd_class_t cls_c;
	logic [3:0]  opc_c;
	logic        two_cyc_c;
	always_comb begin
		w   = fetch_word;
		top = w[`RIFD_TOP_HI:`RIFD_TOP_LO];
		unique case (top)
			`RIFD_TOP_BYTE: cls_c = rifd_pkg::RIFD_CLS_BYTE;
			`RIFD_TOP_BIT:  cls_c = rifd_pkg::RIFD_CLS_BIT;
			default:        cls_c = rifd_pkg::RIFD_CLS_LIT;
		endcase
		// Bit ops carry only two opcode bits; the rest is the bit index
		opc_c = (top == `RIFD_TOP_BIT) ? {2'h0, w[11:10]} : w[11:8];
		// Don't-care bits never enter a comparison below
		two_cyc_c = (top == `RIFD_TOP_JUMP)
			|| (top == `RIFD_TOP_LIT && w[11:10] == `RIFD_OP_RETLW_HI)
			|| (w == `RIFD_RETURN) || (w == `RIFD_RETFIE)
			|| (cond_true && top == `RIFD_TOP_BIT && w[11])
			|| (cond_true && top == `RIFD_TOP_BYTE
				&& (w[11:8] == `RIFD_OP_DECSZ || w[11:8] == `RIFD_OP_INCSZ));
	end
	// ----------------------------------------
	// Registered fields, loaded once per cycle
	// ----------------------------------------
	logic [13:0] word_q, word_d;
	rifd_pkg::rifd_class_t cls_q, cls_d;
	logic [3:0]  opc_q, opc_d;
	logic        jmp_q, jmp_d;
	logic        nop_q, nop_d;
	logic        flush_q, flush_d;
	logic        stb_q, stb_d;
	logic [1:0]  ph_q, ph_d;
	always_comb begin
		word_d  = word_q;
		cls_d   = cls_q;
		opc_d   = opc_q;
		jmp_d   = jmp_q;
		nop_d   = nop_q;
		flush_d = flush_q;
		stb_d   = cyc_start;
		ph_d    = phase;
		if (cyc_start) begin
			if (flush_q) begin
				// Prefetched word is dropped; a NOP stands in
				word_d  = `RIFD_NOP_WORD;
				cls_d   = rifd_pkg::RIFD_CLS_BYTE;
				opc_d   = 4'h0;
				jmp_d   = 1'b0;
				nop_d   = 1'b1;
				flush_d = 1'b0;
			end else begin
				word_d  = w;
				cls_d   = cls_c;
				opc_d   = opc_c;
				jmp_d   = (top == `RIFD_TOP_JUMP);
				nop_d   = 1'b0;
				flush_d = two_cyc_c;
			end
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			word_q  <= 14'h0000;
			cls_q   <= rifd_pkg::RIFD_CLS_BYTE;
			opc_q   <= 4'h0;
			jmp_q   <= 1'b0;
			nop_q   <= 1'b1;
			flush_q <= 1'b0;
			stb_q   <= 1'b0;
			ph_q    <= 2'h0;
		end else begin
			word_q  <= word_d;
			cls_q   <= cls_d;
			opc_q   <= opc_d;
			jmp_q   <= jmp_d;
			nop_q   <= nop_d;
			flush_q <= flush_d;
			stb_q   <= stb_d;
			ph_q    <= ph_d;
		end
	end
	// ----------------------------------------
	// Outputs: fields are slices of registered word; class, opcode and flags come from their own registers
	// ----------------------------------------
	assign insn_class   = cls_q;
	assign op_code      = opc_q;
	assign dest_file    = word_q[`RIFD_DEST_BIT];
	assign file_addr    = word_q[`RIFD_FILE_W-1:0];
	assign bit_index    = word_q[`RIFD_BIT_LO+`RIFD_BIT_W-1:`RIFD_BIT_LO];
	assign lit8         = word_q[`RIFD_LIT8_W-1:0];
	assign lit11        = word_q[`RIFD_LIT11_W-1:0];
	assign is_jump      = jmp_q;
	assign is_nop_cycle = nop_q;
	assign cyc_strobe   = stb_q;
	assign cyc_phase    = ph_q;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	stable_fields_a: assert property (@(posedge core_clk) disable iff (rst)
		!stb_d |=> $stable(word_q) && $stable(cls_q)) else $error("fields moved mid-cycle");
	skip_nop_a: assert property (@(posedge core_clk) disable iff (rst)
		(cyc_start && !flush_q && two_cyc_c) |=> ##4 nop_q && word_q == 14'h0000)
		else $error("no NOP after two-cycle op");
	one_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
		(cyc_start && !flush_q && !two_cyc_c) |=> ##4 !nop_q) else $error("spurious NOP");
	class_bit_a: assert property (@(posedge core_clk) disable iff (rst)
		(stb_q && !nop_q && word_q[13:12] == 2'h1) |-> cls_q == rifd_pkg::RIFD_CLS_BIT)
		else $error("bit class wrong");
	class_byte_a: assert property (@(posedge core_clk) disable iff (rst)
		(stb_q && word_q[13:12] == 2'h0) |-> cls_q == rifd_pkg::RIFD_CLS_BYTE)
		else $error("byte class wrong");
	class_lit_a: assert property (@(posedge core_clk) disable iff (rst)
		(stb_q && word_q[13]) |-> cls_q == rifd_pkg::RIFD_CLS_LIT) else $error("lit class wrong");
	load_word_a: assert property (@(posedge core_clk) disable iff (rst)
		(cyc_start && !flush_q) |=> word_q == $past(fetch_word)) else $error("word not loaded");
	strobe_gap_a: assert property (@(posedge core_clk) disable iff (rst)
		stb_q |=> !stb_q[*3] ##1 stb_q) else $error("cycle not four clocks");
	no_double_nop_a: assert property (@(posedge core_clk) disable iff (rst)
		(stb_q && nop_q) |=> flush_q == 1'b0) else $error("flush stuck");
	cov_skip_c: cover property (@(posedge core_clk) stb_q && nop_q);
	cov_jump_c: cover property (@(posedge core_clk) stb_q && jmp_q);
	cov_bit_c: cover property (@(posedge core_clk) stb_q && cls_q == rifd_pkg::RIFD_CLS_BIT);
endmodule // rifd_decoder

// >>> hw/rifd_phase_gen.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/10ps
`include "rifd_params.svh"
module rifd_phase_gen #(
	parameter int PHASES = `RIFD_PHASES
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	output logic      [`RIFD_PH_W-1:0]  phase,
	output logic                        cyc_start
);
	initial begin
		if (PHASES != 4) $error("rifd_phase_gen: only four phases are supported");
	end
	logic [`RIFD_PH_W-1:0] ph_q;
	logic [`RIFD_PH_W-1:0] ph_d;
	logic                  st_q;
	logic                  st_d;
	always_comb begin
		ph_d = ph_q + 2'h1;
		st_d = (ph_q == 2'h3);
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ph_q <= 2'h0;
			st_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			st_q <= st_d;
		end
	end
	assign phase     = ph_q;
	assign cyc_start = st_q;
	phase_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
		(ph_q == 2'h3) |=> (ph_q == 2'h0)) else $error("phase did not wrap");
	start_space_a: assert property (@(posedge core_clk) disable iff (rst)
		st_q |=> !st_q[*3] ##1 st_q) else $error("cycle start not every four");
endmodule // rifd_phase_gen

// >>> tb/rifd_decoder_bench.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/10ps
module rifd_decoder_bench;
	logic                 core_clk;
	logic                 rst;
	logic [13:0]          fetch_word;
	logic                 cond_true;
	rifd_pkg::rifd_class_t insn_class;
	logic [3:0]           op_code;
	logic                 dest_file;
	logic [6:0]           file_addr;
	logic [2:0]           bit_index;
	logic [7:0]           lit8;
	logic [10:0]          lit11;
	logic                 is_jump;
	logic                 is_nop_cycle;
	logic                 cyc_strobe;
	logic [1:0]           cyc_phase;
	logic [38:0]          seen;
	logic [38:0]          want;
	logic [38:0]          held;
	int                   n_fail;
	int                   compares;
	int                   cycles;
	int                   gap;
	bit                   skip;
	bit                   first;

	localparam logic [38:0] NOP_V = {3'h1, 35'h0, 1'b1};

	rifd_decoder uut (
		.core_clk(core_clk), .rst(rst), .fetch_word(fetch_word), .cond_true(cond_true),
		.insn_class(insn_class), .op_code(op_code), .dest_file(dest_file),
		.file_addr(file_addr), .bit_index(bit_index), .lit8(lit8), .lit11(lit11),
		.is_jump(is_jump), .is_nop_cycle(is_nop_cycle), .cyc_strobe(cyc_strobe),
		.cyc_phase(cyc_phase)
	);

	rifd_fetch_model fetch (
		.core_clk(core_clk), .rst(rst), .cyc_strobe(cyc_strobe),
		.fetch_word(fetch_word), .cond_true(cond_true)
	);

	always #5 core_clk = ~core_clk;

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic [38:0] decode_of(logic [13:0] w);
		logic [2:0] c;
		logic [3:0] op;
		c  = (w[13:12] == 2'h0) ? 3'h1 : (w[13:12] == 2'h1) ? 3'h2 : 3'h4;
		op = (w[13:12] == 2'h1) ? {2'h0, w[11:10]} : w[11:8];
		return {c, op, w[7], w[6:0], w[9:7], w[7:0], w[10:0], w[13:12] == 2'h2, 1'b0};
	endfunction

	function automatic bit two_cycle(logic [13:0] w, logic c);
		return w[13:12] == 2'h2 || w[13:10] == 4'hD || w == 14'h0008 || w == 14'h0009
			|| (c && (w[13:11] == 3'h3 || w[13:8] == 6'h0B || w[13:8] == 6'h0F));
	endfunction

	task automatic check(string what, logic [39:0] exp, logic [39:0] got);
		compares++;
		if (exp !== got) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ----------------------------------------
	// Checks at every falling edge
	// ----------------------------------------
	always @(negedge core_clk) begin
		seen = {insn_class, op_code, dest_file, file_addr, bit_index, lit8, lit11,
			is_jump, is_nop_cycle};
		if (rst) begin
			gap   = 0;
			skip  = 0;
			first = 1;
			held  = NOP_V;
			check("reset", {NOP_V, 1'b0}, {seen, cyc_strobe});
		end else begin
			gap++;
			if (cyc_strobe) begin
				check("cycle length", first ? 5 : 4, gap);
				want  = skip ? NOP_V : decode_of(fetch_word);
				check("fields", want, seen);
				skip  = skip ? 0 : two_cycle(fetch_word, cond_true);
				held  = seen;
				gap   = 0;
				first = 0;
			end else begin
				check("held fields", held, seen);
			end
		end
	end

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic print_verdict();
		$display("Counts: %0d compares, %0d mismatches", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Whole run is about 1630 cycles, so this only trips on a hang
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			$display("Error timeout expected finish seen none");
			print_verdict();
		end
	end

	initial begin
		core_clk = 1'b0;
		rst      = 1'b1;
		repeat (16) @(negedge core_clk);
		rst <= 1'b0;
		repeat (800) @(negedge core_clk);
		$display("Test random stream done");
		// Reset lands at phase 0 of the instruction cycle, while cycle start is high
		rst <= 1'b1;
		repeat (16) @(negedge core_clk);
		rst <= 1'b0;
		repeat (800) @(negedge core_clk);
		$display("Test reset in mid run done");
		print_verdict();
	end
endmodule // rifd_decoder_bench

// >>> tb/rifd_fetch_model.sv
// Program fetch path model feeding words to the decoder
`timescale 1ns/10ps
module rifd_fetch_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        cyc_strobe,
	output logic      [13:0] fetch_word,
	output logic             cond_true
);
	integer      seed = 32'hD1EE;
	logic [31:0] r;

	initial begin
		fetch_word = 14'h0000;
		cond_true  = 1'b0;
	end

	// ----------------------------------------
	// Word stream
	// ----------------------------------------
	// A new word only after the decoder took the last one, so each load sees one word
	always @(negedge core_clk) begin
		if (rst || cyc_strobe) begin
			r = $random(seed);
			// Exact return words are rare in random data, so mix them in on purpose
			fetch_word <= (r[19:17] == 3'h0) ? {13'h0004, r[16]} : r[13:0];
			cond_true  <= r[20];
		end
	end
endmodule // rifd_fetch_model
